// *** hlc_frame_codec.sv ***
`timescale 1ns/1ps
`include "hlc_map.svh"

// first-in first-out store on flip-flops
module hlc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [AW-1:0]    wrPtr_q;        // write index
  logic [AW-1:0]    rdPtr_q;        // read index
  logic [AW:0]      count_q;        // words held
  logic [AW:0]      count_d;        // next word count
  logic             push;           // word accepted
  logic             pop;            // word drained

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];

  // next fill level
  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  // pointers, level and registered ready
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b1;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_d;
      inReady <= (count_d != (AW+1)'(DEPTH));  // back-pressure on full
    end
  end

  // data write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wrPtr_q] <= inData;
  end
endmodule // hlc_fifo

// Function
// - command channel: one address byte, bit0 set
// - selector 0..4 defined, 5..7 reserved
// - data field holds at most 26 bytes
// - length derived only from flag positions
// - 16-bit crc, generator x16 x12 x5 1
// - crc over address and data, not flags
// - frames with bad crc dropped silently
// - deliver frame tagged by its address channel
// - transmit frames in order handed over
// - escape 7D and 7E after frame assembled
// - hunt for first flag as frame start
// - undo escape pairs while assembling
// - closing flag may also open next frame
// - lap frame: control byte plus info
// - i-frame control: 0, ns, poll, nr
// - decode rr rnr rej sabm ua patterns
// - nr acknowledges opposite direction frames
// - poll requests status, final answers poll
// - sequence numbers modulo eight
// - new frame next number, resend keeps
// - i-frames carry reverse acknowledgement
// - at most four unacknowledged i-frames
// - flags delimit, repeated flags are idle
// - address ends at bit0 set, data two bytes
// - command/response sense depends on direction
module hlc_frame_codec (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        rxByte,
  input  wire logic              rxValid,
  output logic      [7:0]        txSerByte,
  output logic                   txSerValid,
  input  wire logic              txSerReady,
  input  hlc_pkg::hlcTxWord_t    txWord,
  input  wire logic              txValid,
  output logic                   txReady,
  output hlc_pkg::hlcRxHdr_t     lapHdr,
  output logic      [7:0]        lapByte,
  output logic                   lapValid,
  output logic                   lapLast,
  input  wire logic              lapReady,
  output logic                   frameGood,
  output logic                   frameDrop,
  output logic                   windowFull
);
  // byte update of the check sequence
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `HLC_CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // control byte classification
  function automatic hlc_pkg::hlcCtlKind_t decodeCtl(input logic [7:0] c);
    hlc_pkg::hlcCtlKind_t k;
    k = hlc_pkg::CTL_UNK;
    if (!c[0])
      k = hlc_pkg::CTL_I;
    else if (c[3:0] == 4'h1)
      k = hlc_pkg::CTL_RR;
    else if (c[3:0] == 4'h5)
      k = hlc_pkg::CTL_RNR;
    else if (c[3:0] == 4'h9)
      k = hlc_pkg::CTL_REJ;
    else if ({c[7:5], c[3:0]} == 7'h1F)
      k = hlc_pkg::CTL_SABM;
    else if ({c[7:5], c[3:0]} == 7'h33)
      k = hlc_pkg::CTL_UA;
    return k;
  endfunction

  // ---------------- receive side ----------------
  hlc_pkg::hlcRxState_t rxState_q;  // framer state
  logic [7:0]  buf_q [`HLC_RX_DEPTH];  // de-stuffed frame bytes
  logic [5:0]  idx_q;               // bytes held
  logic        esc_q;               // escape seen
  logic        addrDone_q;          // last address byte seen
  logic [1:0]  addrLen_q;           // address length
  logic        over_q;              // frame malformed or too long
  logic [15:0] rxCrc_q;             // running check
  logic [5:0]  rdIdx_q;             // delivery index
  logic [5:0]  lastIdx_q;           // last delivered index
  logic [2:0]  ackNr_q;             // latest acknowledgement seen
  logic [7:0]  rxData;              // de-stuffed byte
  logic        rxStore;             // byte goes into frame
  logic        rxEnd;               // flag inside frame
  logic        rxOk;                // closed frame passes checks
  logic [5:0]  minLen;              // address, control, check
  logic [7:0]  ctlByte;             // control byte of held frame
  hlc_pkg::hlcRxHdr_t hdrDec;       // header of held frame

  assign rxData  = esc_q ? (rxByte ^ `HLC_ESC_XOR) : rxByte;
  assign rxStore = rxValid && (rxState_q == hlc_pkg::RX_FRAME)
                   && (rxByte != `HLC_FLAG) && (rxByte != `HLC_ESC);
  assign rxEnd   = rxValid && (rxState_q == hlc_pkg::RX_FRAME)
                   && (rxByte == `HLC_FLAG);
  assign minLen  = {4'h0, addrLen_q} + 6'h1 + `HLC_FCS_LEN;
  assign ctlByte = buf_q[addrLen_q];

  // length only from flag positions, crc residue over whole body
  assign rxOk = (rxCrc_q == `HLC_CRC_GOOD) && addrDone_q && !over_q
                && (idx_q >= minLen)
                && ((idx_q - minLen) <= `HLC_MAX_INFO);

  // address and control decoding of the held frame
  always_comb
  begin
    hdrDec = '0;
    hdrDec.cmdChan = (addrLen_q == 2'h1);
    hdrDec.handle  = hdrDec.cmdChan ? 7'h00 : buf_q[0][7:1];
    hdrDec.newLinkFlag    = buf_q[addrLen_q - 2'h1][`HLC_A_NLF];
    hdrDec.servicePointId = buf_q[addrLen_q - 2'h1][`HLC_A_SERVICE_POINT_ID_HI:`HLC_A_SERVICE_POINT_ID_LO];
    hdrDec.isCommand      = buf_q[addrLen_q - 2'h1][`HLC_A_CR];
    if (hdrDec.cmdChan)
    begin
      hdrDec.protocolSelector = buf_q[0][`HLC_A_PROTOCOL_SELECTOR_HI:`HLC_A_PROTOCOL_SELECTOR_LO];
      hdrDec.protReserved     = (buf_q[0][`HLC_A_PROTOCOL_SELECTOR_HI:`HLC_A_PROTOCOL_SELECTOR_LO] >= `HLC_PROTOCOL_SELECTOR_RSV);
    end
    else
      hdrDec.more = buf_q[1][`HLC_A_MORE];
    hdrDec.kind      = decodeCtl(ctlByte);
    hdrDec.ns        = ctlByte[`HLC_C_NS_HI:`HLC_C_NS_LO];
    hdrDec.nr        = ctlByte[`HLC_C_NR_HI:`HLC_C_NR_LO];
    hdrDec.pollFinal = ctlByte[`HLC_C_PF];
  end

  // receive framer state and counters
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxState_q  <= hlc_pkg::RX_HUNT;
      idx_q      <= '0;
      esc_q      <= 1'b0;
      addrDone_q <= 1'b0;
      addrLen_q  <= '0;
      over_q     <= 1'b0;
      rxCrc_q    <= `HLC_CRC_INIT;
      rdIdx_q    <= '0;
      lastIdx_q  <= '0;
    end
    else
    begin
      unique case (rxState_q)
        hlc_pkg::RX_HUNT:
        begin
          if (rxValid && rxByte == `HLC_FLAG)
            rxState_q <= hlc_pkg::RX_FRAME;
        end
        hlc_pkg::RX_FRAME:
        begin
          if (rxEnd)
          begin
            // closing flag also opens the next frame
            idx_q      <= '0;
            esc_q      <= 1'b0;
            addrDone_q <= 1'b0;
            addrLen_q  <= '0;
            over_q     <= 1'b0;
            rxCrc_q    <= `HLC_CRC_INIT;
            if (idx_q != '0 && rxOk)
            begin
              rxState_q <= hlc_pkg::RX_SEND;
              rdIdx_q   <= {4'h0, addrLen_q};
              lastIdx_q <= idx_q - `HLC_FCS_LEN - 6'h1;
            end
          end
          else if (rxValid && rxByte == `HLC_ESC)
            esc_q <= 1'b1;
          else if (rxStore)
          begin
            esc_q   <= 1'b0;
            rxCrc_q <= crcByte(rxCrc_q, rxData);
            if (idx_q < `HLC_RX_LIMIT)
              idx_q <= idx_q + 6'h1;
            else
              over_q <= 1'b1;
            if (!addrDone_q)
            begin
              if (rxData[`HLC_A_EA])
              begin
                addrDone_q <= 1'b1;
                addrLen_q  <= idx_q[1:0] + 2'h1;
              end
              else if (idx_q != '0)
                over_q <= 1'b1;                    // address longer than two
            end
          end
        end
        hlc_pkg::RX_SEND:
        begin
          // bytes arriving meanwhile are lost; closing flag opened the next frame
          if (!lapValid || lapReady)
          begin
            if (rdIdx_q <= lastIdx_q)
              rdIdx_q <= rdIdx_q + 6'h1;
            else
              rxState_q <= hlc_pkg::RX_FRAME;
          end
        end
        default:
          rxState_q <= hlc_pkg::RX_HUNT;
      endcase
    end
  end

  // frame byte store
  always_ff @(posedge clk)
  begin
    if (rxStore && idx_q < `HLC_RX_LIMIT)
      buf_q[idx_q[4:0]] <= rxData;
  end

  // delivery to the lap instance named in the header
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lapHdr   <= '0;
      lapByte  <= '0;
      lapValid <= 1'b0;
      lapLast  <= 1'b0;
    end
    else
    begin
      if (rxEnd && idx_q != '0 && rxOk)
        lapHdr <= hdrDec;
      if (lapValid && lapReady)
        lapValid <= 1'b0;
      if (rxState_q == hlc_pkg::RX_SEND && (!lapValid || lapReady)
          && rdIdx_q <= lastIdx_q)
      begin
        lapByte  <= buf_q[rdIdx_q[4:0]];
        lapValid <= 1'b1;
        lapLast  <= (rdIdx_q == lastIdx_q);
      end
    end
  end

  // frame outcome pulses and latest acknowledgement
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      frameGood <= 1'b0;
      frameDrop <= 1'b0;
      ackNr_q   <= '0;
    end
    else
    begin
      frameGood <= rxEnd && idx_q != '0 && rxOk;
      frameDrop <= rxEnd && idx_q != '0 && !rxOk;
      if (rxEnd && idx_q != '0 && rxOk && hdrDec.kind <= hlc_pkg::CTL_REJ)
        ackNr_q <= hdrDec.nr;
    end
  end

  // ---------------- transmit side ----------------
  hlc_pkg::hlcTxWord_t fifoWord;    // head of queue
  logic        fifoValid;           // head present
  logic        fifoPop;             // head consumed
  hlc_pkg::hlcTxState_t txState_q;  // framer state
  logic        escPend_q;           // second half of escape pending
  logic [15:0] txCrc_q;             // running check
  logic [5:0]  txCnt_q;             // lap bytes sent in frame
  logic [7:0]  addr1_q;             // first address byte
  logic [7:0]  addr2_q;             // final address byte
  logic [7:0]  raw;                 // unstuffed byte for this slot
  logic        stuffable;           // byte lies between flags
  logic        canGo;               // byte available
  logic        slot;                // serial output free
  logic        go;                  // byte leaves this cycle
  logic        needEsc;             // byte must be escaped
  logic        adv;                 // raw byte fully sent
  logic        dropExcess;          // info beyond limit discarded
  logic        winBlock;            // i-frame beyond window
  logic [2:0]  pending;             // frames ahead of acknowledgement
  logic [7:0]  emit;                // byte placed on the line

  hlc_fifo #(
    .WIDTH ($bits(hlc_pkg::hlcTxWord_t)),
    .DEPTH (`HLC_TX_DEPTH)
  ) u_txq (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   (txWord),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoWord)
  );

  // window guard on the head frame's own send number
  assign pending  = fifoWord.data[`HLC_C_NS_HI:`HLC_C_NS_LO] - ackNr_q;
  assign winBlock = !fifoWord.data[0] && (pending >= `HLC_WINDOW_K);
  assign slot     = !txSerValid || txSerReady;
  assign dropExcess = (txState_q == hlc_pkg::TX_BODY) && fifoValid
                      && (txCnt_q > `HLC_MAX_INFO);

  // byte selection for the current state
  always_comb
  begin
    raw       = `HLC_FLAG;
    stuffable = 1'b1;
    canGo     = 1'b1;
    unique case (txState_q)
      hlc_pkg::TX_IDLE:
      begin
        stuffable = 1'b0;
        canGo     = fifoValid && !winBlock;
      end
      hlc_pkg::TX_ADDR1: raw = addr1_q;
      hlc_pkg::TX_ADDR2: raw = addr2_q;
      hlc_pkg::TX_BODY:
      begin
        raw   = fifoWord.data;
        canGo = fifoValid && !dropExcess;
      end
      hlc_pkg::TX_FCS1: raw = ~txCrc_q[7:0];
      hlc_pkg::TX_FCS2: raw = ~txCrc_q[15:8];
      hlc_pkg::TX_CLOSE: stuffable = 1'b0;
      default: canGo = 1'b0;
    endcase
  end

  assign go      = slot && canGo;
  assign needEsc = stuffable && !escPend_q && (raw == `HLC_FLAG || raw == `HLC_ESC);
  assign adv     = go && !needEsc;
  assign fifoPop = (adv && txState_q == hlc_pkg::TX_BODY) || dropExcess;
  assign emit    = escPend_q ? (raw ^ `HLC_ESC_XOR)
                   : (needEsc ? `HLC_ESC : raw);

  // transmit framer sequencing
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txState_q <= hlc_pkg::TX_IDLE;
      escPend_q <= 1'b0;
      txCrc_q   <= `HLC_CRC_INIT;
      txCnt_q   <= '0;
      addr1_q   <= '0;
      addr2_q   <= '0;
    end
    else
    begin
      if (go)
        escPend_q <= needEsc;
      if (adv)
      begin
        unique case (txState_q)
          hlc_pkg::TX_IDLE:
          begin
            // frames leave in queue order
            txCrc_q <= `HLC_CRC_INIT;
            txCnt_q <= '0;
            addr1_q <= {fifoWord.hdr.handle, 1'b0};
            if (fifoWord.hdr.cmdChan)
            begin
              addr2_q <= {fifoWord.hdr.newLinkFlag, fifoWord.hdr.protocolSelector,
                          fifoWord.hdr.servicePointId, fifoWord.hdr.isResponse, 1'b1};
              txState_q <= hlc_pkg::TX_ADDR2;
            end
            else
            begin
              addr2_q <= {fifoWord.hdr.newLinkFlag, 3'h0, fifoWord.hdr.servicePointId,
                          fifoWord.hdr.isResponse, 1'b1};
              txState_q <= hlc_pkg::TX_ADDR1;
            end
          end
          hlc_pkg::TX_ADDR1:
          begin
            txCrc_q   <= crcByte(txCrc_q, raw);
            txState_q <= hlc_pkg::TX_ADDR2;
          end
          hlc_pkg::TX_ADDR2:
          begin
            txCrc_q   <= crcByte(txCrc_q, raw);
            txState_q <= hlc_pkg::TX_BODY;
          end
          hlc_pkg::TX_BODY:
          begin
            txCrc_q <= crcByte(txCrc_q, raw);
            txCnt_q <= txCnt_q + 6'h1;
            if (fifoWord.last)
              txState_q <= hlc_pkg::TX_FCS1;
          end
          hlc_pkg::TX_FCS1: txState_q <= hlc_pkg::TX_FCS2;
          hlc_pkg::TX_FCS2: txState_q <= hlc_pkg::TX_CLOSE;
          hlc_pkg::TX_CLOSE: txState_q <= hlc_pkg::TX_IDLE;
          default: txState_q <= hlc_pkg::TX_IDLE;
        endcase
      end
      else if (dropExcess && fifoWord.last)
        txState_q <= hlc_pkg::TX_FCS1;
    end
  end

  // serial output register and window status
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txSerByte  <= '0;
      txSerValid <= 1'b0;
      windowFull <= 1'b0;
    end
    else
    begin
      if (go)
      begin
        txSerByte  <= emit;
        txSerValid <= 1'b1;
      end
      else if (txSerReady)
        txSerValid <= 1'b0;
      windowFull <= fifoValid && winBlock && txState_q == hlc_pkg::TX_IDLE;
    end
  end
endmodule // hlc_frame_codec

// *** hlc_map.svh ***
`ifndef HLC_MAP_SVH
`define HLC_MAP_SVH
// delimiter and transparency bytes
`define HLC_FLAG      8'h7E
`define HLC_ESC       8'h7D
`define HLC_ESC_XOR   8'h20
// check sequence, reflected form of the 16/12/5/0 generator
`define HLC_CRC_INIT  16'hFFFF
`define HLC_CRC_POLY  16'h8408
`define HLC_CRC_GOOD  16'hF0B8
// address byte fields
`define HLC_A_EA      0
`define HLC_A_CR      1
`define HLC_A_SERVICE_POINT_ID_LO 2
`define HLC_A_SERVICE_POINT_ID_HI 3
`define HLC_A_MORE    4
`define HLC_A_PROTOCOL_SELECTOR_LO 4
`define HLC_A_PROTOCOL_SELECTOR_HI 6
`define HLC_A_NLF     7
// control byte fields
`define HLC_C_NS_LO   1
`define HLC_C_NS_HI   3
`define HLC_C_PF      4
`define HLC_C_NR_LO   5
`define HLC_C_NR_HI   7
// sizes and limits
`define HLC_MAX_INFO  6'h1A
`define HLC_FCS_LEN   6'h02
`define HLC_RX_DEPTH  32
`define HLC_RX_LIMIT  6'h20
`define HLC_TX_DEPTH  32
`define HLC_WINDOW_K  3'h4
`define HLC_PROTOCOL_SELECTOR_RSV  3'h5
`endif

// *** hlc_pkg.sv ***
package hlc_pkg;
  // decoded lap control byte kinds
  typedef enum logic [2:0] {
    CTL_I    = 3'h0,
    CTL_RR   = 3'h1,
    CTL_RNR  = 3'h2,
    CTL_REJ  = 3'h3,
    CTL_SABM = 3'h4,
    CTL_UA   = 3'h5,
    CTL_UNK  = 3'h6
  } hlcCtlKind_t;
  // receive framer states
  typedef enum logic [1:0] {
    RX_HUNT  = 2'h0,
    RX_FRAME = 2'h1,
    RX_SEND  = 2'h2
  } hlcRxState_t;
  // transmit framer states
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_ADDR1 = 3'h1,
    TX_ADDR2 = 3'h2,
    TX_BODY  = 3'h3,
    TX_FCS1  = 3'h4,
    TX_FCS2  = 3'h5,
    TX_CLOSE = 3'h6
  } hlcTxState_t;
  // channel address of an outgoing frame
  typedef struct packed {
    logic       cmdChan;
    logic [6:0] handle;
    logic [2:0] protocolSelector;
    logic [1:0] servicePointId;
    logic       newLinkFlag;
    logic       isResponse;
  } hlcTxHdr_t;
  // one byte of an outgoing lap frame
  typedef struct packed {
    hlcTxHdr_t  hdr;
    logic [7:0] data;
    logic       last;
  } hlcTxWord_t;
  // decoded header of a delivered frame
  typedef struct packed {
    logic        cmdChan;
    logic [6:0]  handle;
    logic [2:0]  protocolSelector;
    logic        protReserved;
    logic [1:0]  servicePointId;
    logic        newLinkFlag;
    logic        more;
    logic        isCommand;
    hlcCtlKind_t kind;
    logic [2:0]  ns;
    logic [2:0]  nr;
    logic        pollFinal;
  } hlcRxHdr_t;
endpackage

// *** hlc_codec_props.sv ***
`timescale 1ns/1ps
// port-level checks for the frame codec
module hlc_codec_props (
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic [7:0]    rxByte,
  input wire logic          rxValid,
  input wire logic [7:0]    txSerByte,
  input wire logic          txSerValid,
  input wire logic          txSerReady,
  input hlc_pkg::hlcRxHdr_t lapHdr,
  input wire logic [7:0]    lapByte,
  input wire logic          lapValid,
  input wire logic          lapLast,
  input wire logic          lapReady,
  input wire logic          frameGood,
  input wire logic          frameDrop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ser_hold: assert property (
    txSerValid && !txSerReady |=> txSerValid && $stable(txSerByte))
    else $error("serial byte changed early");
  a_lap_hold: assert property (
    lapValid && !lapReady |=> lapValid && $stable(lapByte) && $stable(lapLast))
    else $error("lap byte changed early");
  a_hdr_steady: assert property (
    lapValid && !(lapReady && lapLast) |=> $stable(lapHdr))
    else $error("header moved in delivery");
  a_good_delivers: assert property (
    frameGood |=> lapValid)
    else $error("good frame not delivered");
  a_drop_silent: assert property (
    frameDrop |=> !lapValid)
    else $error("dropped frame delivered");
  a_close_flag: assert property (
    frameGood || frameDrop |-> $past(rxValid) && $past(rxByte) == 8'h7E)
    else $error("verdict without closing flag");
  a_one_verdict: assert property (
    frameGood |-> !frameDrop ##1 !frameGood)
    else $error("verdict not a single pulse");
  a_last_end: assert property (
    lapValid && lapReady && lapLast |=> !lapValid)
    else $error("bytes after last");
  a_esc_pair: assert property (
    txSerValid && txSerReady && txSerByte == 8'h7D
    |-> ##[1:8] txSerValid && (txSerByte == 8'h5D || txSerByte == 8'h5E))
    else $error("escape not followed by code");
endmodule // hlc_codec_props

bind hlc_frame_codec hlc_codec_props u_props (.clk(clk), .resetn(resetn),
  .rxByte(rxByte), .rxValid(rxValid), .txSerByte(txSerByte),
  .txSerValid(txSerValid), .txSerReady(txSerReady), .lapHdr(lapHdr),
  .lapByte(lapByte), .lapValid(lapValid), .lapLast(lapLast),
  .lapReady(lapReady), .frameGood(frameGood), .frameDrop(frameDrop));

// *** hlc_uart_model.sv ***
`timescale 1ns/1ps
// serial sink: takes bytes, stalls every other cycle when slow
module hlc_uart_model (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] txSerByte,
  input wire logic       txSerValid,
  input wire logic       slow,
  output logic           txSerReady
);
  logic [7:0] got[$]; // accepted bytes in order
  logic       tick_q; // stall phase
  // record each accepted byte
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      tick_q <= 1'b0;
    else
    begin
      tick_q <= ~tick_q;
      if (txSerValid && txSerReady)
        got.push_back(txSerByte);
    end
  assign txSerReady = !slow || tick_q;
endmodule // hlc_uart_model

// *** hlc_frame_codec_tb.sv ***
`timescale 1ns/1ps
// self-checking bench for the frame codec
module hlc_frame_codec_tb;
  logic                 clk = 1'b0;
  logic                 resetn = 1'b0;
  logic [7:0]           rxByte = 8'h00;
  logic                 rxValid = 1'b0;
  logic [7:0]           txSerByte;
  logic                 txSerValid;
  logic                 txSerReady;
  hlc_pkg::hlcTxWord_t  txWord = '0;
  logic                 txValid = 1'b0;
  logic                 txReady;
  hlc_pkg::hlcRxHdr_t   lapHdr;
  hlc_pkg::hlcRxHdr_t   hdrGot;   // header at last byte
  logic [7:0]           lapByte;
  logic                 lapValid;
  logic                 lapLast;
  logic                 lapReady = 1'b0;
  logic                 frameGood;
  logic                 frameDrop;
  logic                 windowFull;
  logic                 slow = 1'b0; // stall both sinks
  logic [7:0]           wq[$];    // built wire bytes
  logic [7:0]           exq[$];   // expected serial bytes
  logic [7:0]           lapGot[$];
  logic [7:0]           q[$];
  logic [7:0]           ctlTab[4] = '{8'h05, 8'h09, 8'h3F, 8'h73};
  hlc_pkg::hlcCtlKind_t kindTab[4] = '{hlc_pkg::CTL_RNR, hlc_pkg::CTL_REJ,
                                       hlc_pkg::CTL_SABM, hlc_pkg::CTL_UA};
  int                   badCount = 0;
  int                   comparisons = 0;
  int                   sz;
  int                   n;

  always #2 clk = ~clk;

  hlc_frame_codec u_dut (.clk(clk), .resetn(resetn), .rxByte(rxByte),
    .rxValid(rxValid), .txSerByte(txSerByte), .txSerValid(txSerValid),
    .txSerReady(txSerReady), .txWord(txWord), .txValid(txValid),
    .txReady(txReady), .lapHdr(lapHdr), .lapByte(lapByte), .lapValid(lapValid),
    .lapLast(lapLast), .lapReady(lapReady), .frameGood(frameGood),
    .frameDrop(frameDrop), .windowFull(windowFull));
  hlc_uart_model u_host (.clk(clk), .resetn(resetn), .txSerByte(txSerByte),
    .txSerValid(txSerValid), .slow(slow), .txSerReady(txSerReady));

  // lap sink, alternating ready while slow
  always @(posedge clk)
    lapReady <= !slow || !lapReady;
  // collect delivered bytes
  always @(negedge clk)
    if (lapValid && lapReady)
    begin
      lapGot.push_back(lapByte);
      if (lapLast)
        hdrGot = lapHdr;
    end

  task automatic endSim;
    if (badCount == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a wait that used up its bound
  task automatic tmo(input int k);
    if (k > 900)
    begin
      chk(k, 900);
      endSim();
    end
  endtask
  // complemented reflected check over given bytes
  function automatic logic [15:0] fcs(input logic [7:0] b[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (b[i])
      for (int k = 0; k < 8; k++)
        c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction
  // delimit, check and stuff one frame into wq
  task automatic build(input logic [7:0] b[$]);
    logic [15:0] f;
    f = fcs(b);
    b.push_back(f[7:0]);
    b.push_back(f[15:8]);
    wq.push_back(8'h7E);
    foreach (b[i])
      if (b[i] == 8'h7E || b[i] == 8'h7D)
      begin
        wq.push_back(8'h7D);
        wq.push_back(b[i] ^ 8'h20);
      end
      else
        wq.push_back(b[i]);
    wq.push_back(8'h7E);
  endtask
  // send wq on the receive stream
  task automatic rxSend;
    foreach (wq[i])
    begin
      @(posedge clk);
      rxByte <= wq[i];
      rxValid <= 1'b1;
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte <= ~rxByte;
    wq.delete();
  endtask
  // verdict, then delivered bytes
  task automatic rxCheck(input logic good, input logic [7:0] e[$]);
    int k = 0;
    lapGot.delete();
    while (!frameGood && !frameDrop && k++ < 900) @(negedge clk);
    tmo(k);
    chk(frameGood, good);
    k = 0;
    while (lapGot.size() != e.size() && k++ < 900) @(posedge clk);
    tmo(k);
    foreach (e[i]) chk(lapGot[i], e[i]);
  endtask
  // queue one lap frame, note its expected serial form
  task automatic txFrame(input hlc_pkg::hlcTxHdr_t h, input logic [7:0] b[$]);
    int k;
    if (h.cmdChan)
      q = '{{h.newLinkFlag, h.protocolSelector, h.servicePointId, h.isResponse, 1'b1}};
    else
      q = '{{h.handle, 1'b0}, {h.newLinkFlag, 3'h0, h.servicePointId, h.isResponse, 1'b1}};
    build({q, b});
    exq = {exq, wq};
    wq.delete();
    @(posedge clk);
    foreach (b[i])
    begin
      txWord <= {h, b[i], i == b.size() - 1};
      txValid <= 1'b1;
      k = 0;
      @(negedge clk);
      while (!txReady && k++ < 900) @(negedge clk);
      tmo(k);
      @(posedge clk);
    end
    txValid <= 1'b0;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    slow <= 1'b1;
    @(negedge clk);
    chk(txReady, 1'b1);
    // i-frames ns 0..4 over selectors 0..4, then a data-channel rr
    txFrame({1'b1, 7'h00, 3'h0, 2'h3, 1'b1, 1'b0}, '{8'h00, 8'h7E, 8'h7D});
    for (int k = 1; k < 5; k++)
    begin
      if (k == 4)
        sz = exq.size();
      txFrame({1'b1, 7'h00, 3'(k), 2'h0, 1'b0, 1'b1}, '{8'(k * 2)});
    end
    txFrame({1'b0, 7'h55, 3'h0, 2'h1, 1'b0, 1'b1}, '{8'h21});
    n = 0;
    while (!(windowFull && u_host.got.size() >= sz) && n++ < 900) @(negedge clk);
    tmo(n);
    n = 0;
    while (u_host.got.size() == sz && n < 40) @(negedge clk) n++;
    chk(u_host.got.size(), sz);
    // junk, doubled flag, then rr with nr 1 and poll
    wq = '{8'h55, 8'h7E};
    build('{8'h13, 8'h31});
    rxSend();
    rxCheck(1'b1, '{8'h31});
    chk({hdrGot.cmdChan, hdrGot.protocolSelector, hdrGot.isCommand, hdrGot.kind,
         hdrGot.nr, hdrGot.pollFinal}, {1'b1, 3'h1, 1'b1, hlc_pkg::CTL_RR, 3'h1, 1'b1});
    n = 0;
    while (u_host.got.size() < exq.size() && n++ < 900) @(negedge clk);
    tmo(n);
    chk(windowFull, 1'b0);
    foreach (exq[i]) chk(u_host.got[i], exq[i]);
    // data-channel i-frame with escaped info
    build('{8'h54, 8'h0D, 8'h46, 8'h7E, 8'h7D, 8'h11});
    rxSend();
    rxCheck(1'b1, '{8'h46, 8'h7E, 8'h7D, 8'h11});
    chk({hdrGot.cmdChan, hdrGot.handle, hdrGot.servicePointId, hdrGot.isCommand,
         hdrGot.kind, hdrGot.ns, hdrGot.nr},
        {1'b0, 7'h2A, 2'h3, 1'b0, hlc_pkg::CTL_I, 3'h3, 3'h2});
    for (int k = 0; k < 4; k++)
    begin
      build('{8'h13 + 8'(k) * 8'h20, ctlTab[k]});
      rxSend();
      rxCheck(1'b1, '{ctlTab[k]});
      chk({hdrGot.kind, hdrGot.protReserved}, {kindTab[k], k > 1});
    end
    // corrupted, too short, too long
    build('{8'h13, 8'h31});
    wq[2] = 8'h30;
    rxSend();
    rxCheck(1'b0, '{});
    build('{8'h13});
    rxSend();
    rxCheck(1'b0, '{});
    q = '{8'h13, 8'h00};
    repeat (38) q.push_back(8'h00);
    build(q);
    rxSend();
    rxCheck(1'b0, '{});
    endSim();
  end
endmodule // hlc_frame_codec_tb
